// *** dv/sram_model.sv ***
// Behavioural model of the 128K x 16 static memory that the host controller drives.
module sram_model #(
  parameter int ACCESS_NS = 55
) (
  // Memory pins
  input  wire logic [16:0] addr_in,
  input  wire logic        chip_select_n_in,
  input  wire logic        write_strobe_n_in,
  input  wire logic        output_enable_n_in,
  input  wire logic        upper_byte_enable_n_in,
  input  wire logic        lower_byte_enable_n_in,
  // Host side of the data bus
  input  wire logic [15:0] host_data_in,
  input  wire logic        host_oe_in,
  // Resolved bus and contention flag
  output logic      [15:0] bus_out,
  output logic             clash_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // Array and access decode
  logic [15:0] mem_r [0:131071];
  logic        wr;
  logic        rd;
  logic        rd_late;
  logic [15:0] word;
  logic [15:0] late;
  logic [1:0]  drv;
  assign wr = !chip_select_n_in && !write_strobe_n_in;
  assign rd = !chip_select_n_in && write_strobe_n_in && !output_enable_n_in;
  assign word = mem_r[addr_in];
  // Data is only trusted once the access time has run out; before that it is garbage.
  assign #(ACCESS_NS) late = word;
  assign #(ACCESS_NS) rd_late = rd;
  assign drv = rd ? {!upper_byte_enable_n_in, !lower_byte_enable_n_in} : 2'b00;
  assign clash_out = host_oe_in && (drv != 2'b00);
  // ==========================================================================
  // Write: an undriven bus stores garbage rather than a lucky value.
  always @* begin
    if (wr && !lower_byte_enable_n_in) begin
      mem_r[addr_in][7:0] = host_oe_in ? host_data_in[7:0] : 8'hxx;
    end
    if (wr && !upper_byte_enable_n_in) begin
      mem_r[addr_in][15:8] = host_oe_in ? host_data_in[15:8] : 8'hxx;
    end
  end
  // ==========================================================================
  // Bus resolution: a floating lane shows the inverse of the stored word.
  always @* begin
    for (int i = 0; i < 2; i++) begin
      if (host_oe_in) begin
        bus_out[i*8+:8] = host_data_in[i*8+:8];
      end else if (drv[i] && rd_late) begin
        bus_out[i*8+:8] = late[i*8+:8];
      end else begin
        bus_out[i*8+:8] = ~word[i*8+:8];
      end
    end
  end
endmodule : sram_model

// *** dv/tb_top.sv ***
// Self-checking testbench for the static memory host controller.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // Signals
  logic        ref_clk_in, rst_n_in, req_valid_in, req_write_in;
  logic [16:0] req_addr_in, mem_addr_out;
  logic [15:0] req_wdata_in, rsp_rdata_out, mem_data_out, bus;
  logic [1:0]  req_lane_en_in;
  logic        req_ready_out, rsp_valid_out, mem_data_oe_out, clash;
  logic        cs_n, we_n, oe_n, ub_n, lb_n;
  int          num_errors, samples_checked, strobe_len;
  sram_host_ctrl uut (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
    .req_valid_in(req_valid_in), .req_write_in(req_write_in), .req_addr_in(req_addr_in),
    .req_wdata_in(req_wdata_in), .req_lane_en_in(req_lane_en_in),
    .req_ready_out(req_ready_out), .rsp_valid_out(rsp_valid_out),
    .rsp_rdata_out(rsp_rdata_out), .mem_addr_out(mem_addr_out), .chip_select_n_out(cs_n),
    .write_strobe_n_out(we_n), .output_enable_n_out(oe_n), .upper_byte_enable_n_out(ub_n),
    .lower_byte_enable_n_out(lb_n), .mem_data_in(bus), .mem_data_out(mem_data_out),
    .mem_data_oe_out(mem_data_oe_out));
  sram_model mem (.addr_in(mem_addr_out), .chip_select_n_in(cs_n), .write_strobe_n_in(we_n),
    .output_enable_n_in(oe_n), .upper_byte_enable_n_in(ub_n), .lower_byte_enable_n_in(lb_n),
    .host_data_in(mem_data_out), .host_oe_in(mem_data_oe_out), .bus_out(bus),
    .clash_out(clash));
  initial begin
    ref_clk_in = 1'b0;
    forever #5 ref_clk_in = ~ref_clk_in;
  end
  // ==========================================================================
  // Shared tasks
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic req(input logic w, input logic [16:0] a, input logic [15:0] d,
                     input logic [1:0] l);
    int n;
    n = 0;
    while (req_ready_out !== 1'b1 && n < 40) begin
      @(negedge ref_clk_in);
      n++;
    end
    check({31'h0, req_ready_out}, 32'h1);
    @(posedge ref_clk_in);
    req_valid_in <= 1'b1;
    req_write_in <= w;
    req_addr_in <= a;
    req_wdata_in <= d;
    req_lane_en_in <= l;
    @(posedge ref_clk_in);
    req_valid_in <= 1'b0;
    @(negedge ref_clk_in);
  endtask : req
  task automatic read_chk(input logic [16:0] a, input logic [1:0] l, input logic [15:0] exp);
    logic [15:0] m;
    int n;
    m = {{8{l[1]}}, {8{l[0]}}};
    n = 0;
    req(1'b0, a, 16'h0000, l);
    while (rsp_valid_out !== 1'b1 && n < 30) begin
      @(negedge ref_clk_in);
      n++;
    end
    check({31'h0, rsp_valid_out}, 32'h1);
    check({16'h0000, rsp_rdata_out & m}, {16'h0000, exp & m});
  endtask : read_chk
  // Strobe monitor: the host must drive data for the whole strobe, long enough.
  always @(negedge ref_clk_in) begin
    if (clash === 1'b1) check(32'h1, 32'h0);
    if (we_n === 1'b0) begin
      strobe_len++;
      if (mem_data_oe_out !== 1'b1) check({31'h0, mem_data_oe_out}, 32'h1);
    end else if (strobe_len != 0) begin
      check(32'(strobe_len * sram_ctrl_pkg::CLK_PERIOD_NS
                >= sram_ctrl_pkg::ADDRESS_SETUP_TO_WRITE_END_NS), 32'h1);
      check({31'h0, cs_n}, 32'h1);
      strobe_len = 0;
    end
  end
  // ==========================================================================
  // Scenarios
  task automatic t_reset;
    check({26'h0, cs_n, we_n, oe_n, ub_n, lb_n, mem_data_oe_out}, 32'h3e);
    check({31'h0, req_ready_out}, 32'h1);
    $display("test reset done");
  endtask : t_reset
  task automatic t_lanes;
    req(1'b1, 17'h00005, 16'h1234, 2'b11);
    req(1'b1, 17'h00005, 16'haa55, 2'b01);
    req(1'b1, 17'h00005, 16'h66ff, 2'b10);
    read_chk(17'h00005, 2'b11, 16'h6655);
    read_chk(17'h00005, 2'b01, 16'h0055);
    read_chk(17'h00005, 2'b10, 16'h6600);
    $display("test lanes done");
  endtask : t_lanes
  task automatic t_bounds;
    req(1'b1, 17'h00000, 16'hc3a5, 2'b11);
    req(1'b1, 17'h1ffff, 16'h5a3c, 2'b11);
    read_chk(17'h00000, 2'b11, 16'hc3a5);
    read_chk(17'h1ffff, 2'b11, 16'h5a3c);
    $display("test bounds done");
  endtask : t_bounds
  task automatic t_mask;
    req(1'b1, 17'h00005, 16'hffff, 2'b00);
    for (int i = 0; i < 4; i++) begin
      check({30'h0, cs_n, we_n}, 32'h3);
      @(negedge ref_clk_in);
    end
    read_chk(17'h00005, 2'b11, 16'h6655);
    $display("test empty mask done");
  endtask : t_mask
  // ==========================================================================
  // Verdict
  task automatic wrap_up;
    $display("checks %0d, mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : wrap_up
  initial begin
    #100000;
    num_errors++;
    wrap_up;
  end
  initial begin
    {rst_n_in, req_valid_in, req_write_in, req_lane_en_in} = 5'h00;
    req_addr_in = 17'h00000;
    req_wdata_in = 16'h0000;
    repeat (16) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    @(negedge ref_clk_in);
    t_reset;
    t_lanes;
    t_bounds;
    t_mask;
    repeat (5) @(negedge ref_clk_in);
    wrap_up;
  end
endmodule : tb_top

// *** rtl/pin_sync.sv ***
// Three-stage synchroniser for the data bus inputs.
module pin_sync #(
  parameter int WIDTH = 16
) (
  // Clock and reset
  input  wire logic             ref_clk_in,
  input  wire logic             rst_n_in,
  // Data
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] s1_r;
  logic [WIDTH-1:0] s2_r;
  logic [WIDTH-1:0] s3_r;

  // ==========================================================================
  // Stages
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      sync_out <= '0;
    end else begin
      s1_r <= async_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      // A bit only changes once the second and third stages agree.
      for (int i = 0; i < WIDTH; i++) begin
        if (s2_r[i] == s3_r[i]) begin
          sync_out[i] <= s3_r[i];
        end
      end
    end
  end
endmodule : pin_sync

// *** rtl/sram_ctrl_pkg.sv ***
// Package of timing constants and states for the static memory host controller.
package sram_ctrl_pkg;
  // ==========================================================================
  // Geometry
  localparam int ADDR_W  = 17;
  localparam int DATA_W  = 16;
  localparam int WORDS   = 131072;
  // ==========================================================================
  // Timing in ns, fast grade selected by default
  localparam int CLK_PERIOD_NS                 = 10;
  localparam int READ_CYCLE_TIME_NS            = 55;
  localparam int ADDRESS_ACCESS_TIME_NS        = 55;
  localparam int SELECT_ACCESS_TIME_NS         = 55;
  localparam int OUTPUT_ENABLE_ACCESS_TIME_NS  = 25;
  localparam int BYTE_ENABLE_ACCESS_TIME_NS    = 25;
  localparam int ADDRESS_CHANGE_OUTPUT_HOLD_NS = 10;
  localparam int WRITE_CYCLE_TIME_NS           = 55;
  localparam int ADDRESS_SETUP_TO_WRITE_END_NS = 45;
  localparam int WRITE_DATA_SETUP_NS           = 25;
  localparam int STROBE_TO_TRISTATE_DELAY_NS   = 20;
  localparam int BUS_TURN_NS                   = 25;
  // ==========================================================================
  // Cycle counts, least times rounded up
  localparam int READ_CYC  = (READ_CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WRITE_CYC = (ADDRESS_SETUP_TO_WRITE_END_NS + CLK_PERIOD_NS - 1)
                             / CLK_PERIOD_NS;
  localparam int WDATA_CYC = (WRITE_DATA_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TURN_CYC  = (BUS_TURN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W     = 4;
  localparam logic [CNT_W-1:0] READ_LAST  = CNT_W'(READ_CYC - 1);
  localparam logic [CNT_W-1:0] WRITE_LAST = CNT_W'(WRITE_CYC - 1);
  localparam logic [CNT_W-1:0] TURN_LAST  = CNT_W'(TURN_CYC - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO   = 4'h0;
  // ==========================================================================
  // States
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_READ  = 2'b01,
    ST_WRITE = 2'b10,
    ST_TURN  = 2'b11
  } state_t;
endpackage : sram_ctrl_pkg

// *** rtl/sram_host_ctrl.sv ***
// Host controller that sequences an asynchronous 128K x 16 static memory.
// ============================================================================
// Overview of operation
// - Write only while select and strobe low.
// - Read: select, output enable low, strobe high.
// - Write interval is select and strobe overlap.
// - Data setup measured from write-ending edge.
// - Strobe-ended write cycle covers tristate plus setup.
// - Host never drives bus during reads.
// - Address stable before write end.
// - Write data present before write end.
module sram_host_ctrl (
  // Clock and reset
  input  wire logic        ref_clk_in,
  input  wire logic        rst_n_in,
  // User request
  input  wire logic        req_valid_in,
  input  wire logic        req_write_in,
  input  wire logic [16:0] req_addr_in,
  input  wire logic [15:0] req_wdata_in,
  input  wire logic [1:0]  req_lane_en_in,
  output logic             req_ready_out,
  // User answer
  output logic             rsp_valid_out,
  output logic [15:0]      rsp_rdata_out,
  // Memory pins
  output logic [16:0]      mem_addr_out,
  output logic             chip_select_n_out,
  output logic             write_strobe_n_out,
  output logic             output_enable_n_out,
  output logic             upper_byte_enable_n_out,
  output logic             lower_byte_enable_n_out,
  input  wire logic [15:0] mem_data_in,
  output logic [15:0]      mem_data_out,
  output logic             mem_data_oe_out
);
  sram_ctrl_pkg::state_t                 state_r;
  logic [sram_ctrl_pkg::CNT_W-1:0]       cnt_r;
  logic [15:0]                           data_sync;
  logic                                  accept;

  // ==========================================================================
  // Input synchroniser
  pin_sync #(
    .WIDTH(16)
  ) u_sync (
    .ref_clk_in(ref_clk_in),
    .rst_n_in  (rst_n_in),
    .async_in  (mem_data_in),
    .sync_out  (data_sync)
  );

  // A request with no lane enabled is finished without asserting select or the strobes; address and data outputs still load.
  assign req_ready_out = (state_r == sram_ctrl_pkg::ST_IDLE);
  assign accept        = req_valid_in && req_ready_out;

  // ==========================================================================
  // Sequencer
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      state_r <= sram_ctrl_pkg::ST_IDLE;
      cnt_r   <= sram_ctrl_pkg::CNT_ZERO;
    end else begin
      case (state_r)
        sram_ctrl_pkg::ST_IDLE: begin
          cnt_r <= sram_ctrl_pkg::CNT_ZERO;
          if (accept && req_lane_en_in != 2'h0) begin
            state_r <= req_write_in ? sram_ctrl_pkg::ST_WRITE : sram_ctrl_pkg::ST_READ;
          end
        end
        sram_ctrl_pkg::ST_READ: begin
          cnt_r <= cnt_r + 4'h1;
          // Sampling waits the access time, the three stages and the held output stage.
          if (cnt_r == sram_ctrl_pkg::READ_LAST + 4'h4) begin
            state_r <= sram_ctrl_pkg::ST_TURN;
            cnt_r   <= sram_ctrl_pkg::CNT_ZERO;
          end
        end
        sram_ctrl_pkg::ST_WRITE: begin
          cnt_r <= cnt_r + 4'h1;
          if (cnt_r == sram_ctrl_pkg::WRITE_LAST) begin
            state_r <= sram_ctrl_pkg::ST_TURN;
            cnt_r   <= sram_ctrl_pkg::CNT_ZERO;
          end
        end
        sram_ctrl_pkg::ST_TURN: begin
          // Recovery lets the memory float its outputs before the next access.
          cnt_r <= cnt_r + 4'h1;
          if (cnt_r == sram_ctrl_pkg::TURN_LAST) begin
            state_r <= sram_ctrl_pkg::ST_IDLE;
          end
        end
        default: begin
          state_r <= sram_ctrl_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // Address, lanes and write data
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      mem_addr_out            <= 17'h00000;
      mem_data_out            <= 16'h0000;
      upper_byte_enable_n_out <= 1'b1;
      lower_byte_enable_n_out <= 1'b1;
    end else if (accept) begin
      mem_addr_out            <= req_addr_in;
      mem_data_out            <= req_wdata_in;
      lower_byte_enable_n_out <= ~req_lane_en_in[0];
      upper_byte_enable_n_out <= ~req_lane_en_in[1];
    end else if (state_r == sram_ctrl_pkg::ST_TURN) begin
      upper_byte_enable_n_out <= 1'b1;
      lower_byte_enable_n_out <= 1'b1;
    end
  end

  // ==========================================================================
  // Control strobes
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      chip_select_n_out   <= 1'b1;
      write_strobe_n_out  <= 1'b1;
      output_enable_n_out <= 1'b1;
      mem_data_oe_out     <= 1'b0;
    end else if (accept && req_lane_en_in != 2'h0) begin
      chip_select_n_out   <= 1'b0;
      write_strobe_n_out  <= ~req_write_in;
      output_enable_n_out <= req_write_in;
      mem_data_oe_out     <= req_write_in;
    end else if ((state_r == sram_ctrl_pkg::ST_READ && cnt_r == sram_ctrl_pkg::READ_LAST
                  + 4'h4) || (state_r == sram_ctrl_pkg::ST_WRITE
                  && cnt_r == sram_ctrl_pkg::WRITE_LAST)) begin
      // Select rises together with the write strobe or output enable; after a read the memory stops driving its outputs.
      chip_select_n_out   <= 1'b1;
      write_strobe_n_out  <= 1'b1;
      output_enable_n_out <= 1'b1;
    end else if (state_r == sram_ctrl_pkg::ST_TURN) begin
      // Data held one cycle past the write end gives zero hold.
      mem_data_oe_out <= 1'b0;
    end
  end

  // ==========================================================================
  // Read answer
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      rsp_valid_out <= 1'b0;
      rsp_rdata_out <= 16'h0000;
    end else begin
      rsp_valid_out <= 1'b0;
      if (state_r == sram_ctrl_pkg::ST_READ && cnt_r == sram_ctrl_pkg::READ_LAST + 4'h4) begin
        rsp_valid_out <= 1'b1;
        rsp_rdata_out <= data_sync;
      end
    end
  end

  // ==========================================================================
  // Checks
  no_contention_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    !(mem_data_oe_out && !output_enable_n_out))
    else $error("Host drives bus while output enable low.");

  write_setup_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    $rose(write_strobe_n_out) |-> $past(!write_strobe_n_out, 5) && $stable(mem_addr_out))
    else $error("Write strobe shorter than address setup.");

  write_data_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    $rose(write_strobe_n_out) |-> mem_data_oe_out && $past(mem_data_oe_out, 3))
    else $error("Write data not set up before strobe end.");

  write_pair_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    !write_strobe_n_out |-> !chip_select_n_out && output_enable_n_out)
    else $error("Write strobe without select.");

  read_space_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    $fell(output_enable_n_out) |-> !output_enable_n_out [*8])
    else $error("Read shorter than access time.");

  joint_rise_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    $rose(write_strobe_n_out) |-> $rose(chip_select_n_out))
    else $error("Strobe and select did not rise together.");

  empty_write_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    accept && req_lane_en_in == 2'h0 |=> chip_select_n_out)
    else $error("Empty lane request touched the memory.");

  read_answer_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    $fell(output_enable_n_out) |-> ##10 rsp_valid_out)
    else $error("Read answer not on time.");

  turn_gap_a: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    $rose(chip_select_n_out) |-> chip_select_n_out [*3])
    else $error("Recovery gap too short.");
endmodule : sram_host_ctrl
